// File: dv/bdma_core_sva.sv
// port assertions for the banked data memory
`timescale 1ns/1ps
`default_nettype none
module bdma_core_sva
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic wdt_sleep_reset_in,
   input wire bdma_pkg::bdma_req_t req_in,
   input wire logic [7:0] rdata_out,
   input wire logic ext_sel_out,
   input wire logic ext_bank_out,
   input wire logic [7:0] ext_addr_out,
   input wire logic ext_write_out,
   input wire logic ext_present_in,
   input wire logic ext_writable_in,
   input wire logic eeprom_control_sel_out,
   input wire logic bank_select_bit_out
);
   import bdma_pkg::*;
   logic direct;
   logic rd_op;
   assign rd_op = req_in.op == bdma_op_read;
   assign direct = req_in.op != bdma_op_none && req_in.addr != 8'h00 && req_in.addr != 8'h02;
   default clocking @(posedge clock_in); endclocking
   sequence s_bp_wr;
      req_in.op == bdma_op_write && req_in.addr == bdma_addr_bank_select;
   endsequence
   // reset checks have no disable: they watch the reset itself
   AST_BANK_CLR: assert property (!reset_n_in && !wdt_sleep_reset_in |=> !bank_select_bit_out)
      else $error("bank bit not cleared by reset");
   AST_BANK_KEEP: assert property (!reset_n_in && wdt_sleep_reset_in |=> $stable(bank_select_bit_out))
      else $error("bank bit lost on watchdog reset");
   AST_BP_WR: assert property (disable iff (!reset_n_in) s_bp_wr |=> bank_select_bit_out == $past(req_in.wdata[0]))
      else $error("bank bit not written");
   AST_BP_RD: assert property (disable iff (!reset_n_in) rd_op && req_in.addr == 8'h04 |=> rdata_out == {7'h00, $past(bank_select_bit_out)})
      else $error("bank select read wrong");
   AST_PROT: assert property (disable iff (!reset_n_in) !ext_writable_in |-> !ext_write_out)
      else $error("write to protected register");
   AST_UNUSED: assert property (disable iff (!reset_n_in) rd_op && ext_sel_out && !ext_present_in |=> rdata_out == 8'h00)
      else $error("unused location not zero");
   AST_DIRECT_BANK: assert property (disable iff (!reset_n_in) direct && ext_sel_out |-> !ext_bank_out && ext_addr_out == req_in.addr)
      else $error("direct access left bank 0");
   AST_DIRECT_EEC: assert property (disable iff (!reset_n_in) direct |-> !eeprom_control_sel_out)
      else $error("eeprom control reached directly");
endmodule
`default_nettype wire

// File: dv/bdma_sfr_model.sv
// outside special registers: one plain, one read-only, rest unused
`timescale 1ns/1ps
`default_nettype none
module bdma_sfr_model
(
   input wire logic clock_in,
   input wire logic sel_in,
   input wire logic write_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic present_out,
   output logic writable_out,
   output logic [7:0] rdata_out
);
   logic [7:0] scratch = 8'h00;
   assign present_out = sel_in && (addr_in == 8'h05 || addr_in == 8'h08);
   assign writable_out = addr_in != 8'h08;
   // unused places drive junk so a missing zero shows up
   assign rdata_out = (addr_in == 8'h05) ? scratch : (addr_in == 8'h08) ? 8'hc3 : 8'h5a;
   always_ff @(posedge clock_in)
   begin
      if (write_in && addr_in == 8'h05)
         scratch <= wdata_in;
   end
endmodule
`default_nettype wire

// File: dv/test_banked_data_memory_addressing.sv
// self-checking bench for the banked data memory
`timescale 1ns/1ps
`default_nettype none
module test_banked_data_memory_addressing;
   import bdma_pkg::*;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic wdt_sleep_reset_in = 1'b0;
   bdma_req_t req_in = '0;
   logic [7:0] rdata_out, ext_addr_out, ext_wdata_out, ext_rdata_in;
   logic ext_sel_out, ext_bank_out, ext_write_out, ext_present_in, ext_writable_in;
   logic eeprom_control_sel_out, bank_select_bit_out, eec_seen;
   int bad_count = 0;
   int n_compared = 0;
   always #5 clock_in = ~clock_in;
   bdma_core #(.gp_depth(64)) bdma_core_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .wdt_sleep_reset_in(wdt_sleep_reset_in), .req_in(req_in), .rdata_out(rdata_out),
      .ext_sel_out(ext_sel_out), .ext_bank_out(ext_bank_out), .ext_addr_out(ext_addr_out),
      .ext_write_out(ext_write_out), .ext_wdata_out(ext_wdata_out),
      .ext_present_in(ext_present_in), .ext_writable_in(ext_writable_in),
      .ext_rdata_in(ext_rdata_in), .eeprom_control_sel_out(eeprom_control_sel_out),
      .bank_select_bit_out(bank_select_bit_out));
   bdma_sfr_model bdma_sfr_model_i (.clock_in(clock_in), .sel_in(ext_sel_out),
      .write_in(ext_write_out), .addr_in(ext_addr_out), .wdata_in(ext_wdata_out),
      .present_out(ext_present_in), .writable_out(ext_writable_in), .rdata_out(ext_rdata_in));
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input bdma_op_t op, input logic [7:0] a, input logic [7:0] d,
      input logic [2:0] b);
      @(posedge clock_in);
      req_in <= '{op, a, d, b};
      #1 eec_seen = eeprom_control_sel_out;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(bdma_op_write, a, d, 3'h0);
   endtask
   // request then idle; read data lands at the idle edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(bdma_op_read, a, 8'h00, 3'h0);
      @(posedge clock_in);
      req_in <= '0;
      #1 check(rdata_out, exp);
   endtask
   task automatic rst(input logic w);
      @(posedge clock_in);
      reset_n_in <= 1'b0;
      wdt_sleep_reset_in <= w;
      req_in <= '0;
      repeat (2) @(posedge clock_in);
      reset_n_in <= 1'b1;
      wdt_sleep_reset_in <= 1'b0;
   endtask
   initial
   begin
      #100000;
      bad_count++;
      end_sim;
   end
   initial
   begin
      repeat (16) @(posedge clock_in);
      reset_n_in <= 1'b1;
      rd(8'h04, 8'h00);
      wr(8'h40, 8'ha5);
      wr(8'h7f, 8'h5a);
      rd(8'h40, 8'ha5);
      rd(8'h7f, 8'h5a);
      acc(bdma_op_bit_set, 8'h40, 8'h00, 3'h1);
      acc(bdma_op_bit_clear, 8'h40, 8'h00, 3'h0);
      rd(8'h40, 8'ha6);
      $display("test general area done");
      wr(8'h01, 8'h41);
      wr(8'h00, 8'h3c);
      rd(8'h01, 8'h41);
      rd(8'h41, 8'h3c);
      wr(8'h03, 8'h00);
      rd(8'h02, 8'h00);
      wr(8'h04, 8'hff);
      rd(8'h04, 8'h01);
      wr(8'h03, 8'h41);
      wr(8'h02, 8'h77);
      rd(8'h41, 8'h3c);
      rd(8'h00, 8'h3c);
      rd(8'h02, 8'h00);
      wr(8'h03, 8'h40);
      acc(bdma_op_read, 8'h02, 8'h00, 3'h0);
      check({7'h00, eec_seen}, 8'h01);
      wr(8'h04, 8'h00);
      rd(8'h02, 8'ha6);
      wr(8'h05, 8'h12);
      wr(8'h08, 8'h00);
      rd(8'h05, 8'h12);
      rd(8'h08, 8'hc3);
      rd(8'h09, 8'h00);
      $display("test windows done");
      wr(8'h04, 8'h01);
      rst(1'b1);
      rd(8'h04, 8'h01);
      rst(1'b0);
      rd(8'h04, 8'h00);
      $display("test reset done");
      end_sim;
   end
endmodule
bind bdma_core bdma_core_sva bdma_core_sva_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
   .wdt_sleep_reset_in(wdt_sleep_reset_in), .req_in(req_in), .rdata_out(rdata_out),
   .ext_sel_out(ext_sel_out), .ext_bank_out(ext_bank_out), .ext_addr_out(ext_addr_out),
   .ext_write_out(ext_write_out), .ext_present_in(ext_present_in),
   .ext_writable_in(ext_writable_in), .eeprom_control_sel_out(eeprom_control_sel_out),
   .bank_select_bit_out(bank_select_bit_out));
`default_nettype wire

// File: hw/bdma_core.sv
// banked data memory: bank-select, pointers, general-purpose ram and window decode
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - byte-wide volatile ram starting at zero
// - two banks; eeprom control only in bank 1
// - 64 general bytes at 40h-7fh, bank 0
// - bit set/clear touches only the bit, except eeprom control (other bits sent as zero)
// - unused special locations read zero
// - protected special registers ignore writes
// - windows act on the pointed location
// - window zero bank 0, window one selected bank
// - pointer at a window: read zero, no write
// - pointers are ordinary read/write storage
// - direct addressing always reaches bank 0
// - bank_select bit 0 chooses the bank
// - reset clears bank, except watchdog wake
// - bank_select bits 7-1 read zero
module bdma_core
#(
   parameter int unsigned gp_depth = 64
)
(
   // clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // reset cause: watchdog time-out while idle or asleep
   input wire logic wdt_sleep_reset_in,
   // access from the execution core
   input wire bdma_pkg::bdma_req_t req_in,
   output logic [7:0] rdata_out,
   // external special registers (timers, ports, status ...)
   output logic ext_sel_out,
   output logic ext_bank_out,
   output logic [7:0] ext_addr_out,
   output logic ext_write_out,
   output logic [7:0] ext_wdata_out,
   input wire logic ext_present_in,
   input wire logic ext_writable_in,
   input wire logic [7:0] ext_rdata_in,
   // eeprom control register strobe (bank 1, 40h)
   output logic eeprom_control_sel_out,
   // bank state
   output logic bank_select_bit_out
);
   import bdma_pkg::*;

   localparam int unsigned gp_aw = $clog2(gp_depth);

   logic [7:0] gp_mem [gp_depth];
   logic [7:0] pointer_zero;
   logic [7:0] pointer_one;
   logic bank_select_bit;
   logic [7:0] next_pointer_zero;
   logic [7:0] next_pointer_one;
   logic next_bank_select_bit;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic gp_we;
   logic [gp_aw-1:0] gp_idx;
   logic [7:0] gp_wdata;
   logic [7:0] cur;
   logic [7:0] mod_val;
   logic is_rd;
   logic is_wr;
   bdma_loc_t loc;

   bdma_resolve u_resolve
   (
      .addr_in(req_in.addr),
      .pointer_zero_in(pointer_zero),
      .pointer_one_in(pointer_one),
      .bank_sel_in(bank_select_bit),
      .loc_out(loc)
   );

   function automatic logic in_gp(input bdma_loc_t l);
      in_gp = !l.bank && (l.addr >= bdma_addr_gp_first) && (l.addr <= bdma_addr_gp_last);
   endfunction

   function automatic logic in_sfr(input bdma_loc_t l);
      in_sfr = (l.addr <= bdma_addr_sfr_last);
   endfunction

   // read-modify-write keeps every other bit of the byte, except at eeprom control, whose other bits go out as zero
   always_comb
   begin
      is_rd = (req_in.op == bdma_op_read);
      is_wr = (req_in.op == bdma_op_write) || (req_in.op == bdma_op_bit_set) ||
              (req_in.op == bdma_op_bit_clear);
      gp_idx = loc.addr[gp_aw-1:0];
      cur = bdma_zero_byte;
      if (loc.null_target)
         cur = bdma_zero_byte;
      else if (in_gp(loc))
         cur = gp_mem[gp_idx];
      else if (in_sfr(loc))
      begin
         unique case (loc.addr)
            bdma_addr_pointer_zero: cur = pointer_zero;
            bdma_addr_pointer_one: cur = pointer_one;
            bdma_addr_bank_select:
               cur = {7'h00, bank_select_bit};
            default: cur = ext_present_in ? ext_rdata_in : bdma_zero_byte;
         endcase
      end
      mod_val = req_in.wdata;
      if (req_in.op == bdma_op_bit_set)
         mod_val = cur | (bdma_one_byte << req_in.bit_sel);
      else if (req_in.op == bdma_op_bit_clear)
         mod_val = cur & ~(bdma_one_byte << req_in.bit_sel);
   end

   // external special-register and eeprom strobes
   always_comb
   begin
      ext_sel_out = 1'b0;
      eeprom_control_sel_out = 1'b0;
      if (!loc.null_target && (is_rd || is_wr))
      begin
         if (loc.bank && (loc.addr == bdma_addr_eeprom_control))
            eeprom_control_sel_out = 1'b1;
         else if (in_sfr(loc) && (loc.addr > bdma_addr_bank_select))
            ext_sel_out = 1'b1;
      end
      ext_bank_out = loc.bank;
      ext_addr_out = loc.addr;
      // protected registers are refused by the owner saying not writable
      ext_write_out = ext_sel_out && is_wr && ext_writable_in;
      ext_wdata_out = mod_val;
   end

   // state update
   always_comb
   begin
      next_pointer_zero = pointer_zero;
      next_pointer_one = pointer_one;
      next_bank_select_bit = bank_select_bit;
      gp_we = 1'b0;
      gp_wdata = mod_val;
      next_rdata = rdata;
      if (is_rd)
         next_rdata = loc.bank && (loc.addr == bdma_addr_eeprom_control) ?
            ext_rdata_in : cur;
      if (is_wr && !loc.null_target)
      begin
         if (in_gp(loc))
            gp_we = 1'b1;
         else if (!loc.bank || in_sfr(loc))
         begin
            unique case (loc.addr)
               bdma_addr_pointer_zero: next_pointer_zero = mod_val;
               bdma_addr_pointer_one: next_pointer_one = mod_val;
               bdma_addr_bank_select:
                  next_bank_select_bit = mod_val[bdma_bank_bit];
               default: ;
            endcase
         end
      end
      // bank 1 has no general-purpose ram; such accesses are dropped
      if (!reset_n_in && !wdt_sleep_reset_in)
         next_bank_select_bit = bdma_bank_select_reset[bdma_bank_bit];
   end

   always_ff @(posedge clock_in)
   begin
      if (!reset_n_in)
      begin
         pointer_zero <= bdma_zero_byte;
         pointer_one <= bdma_zero_byte;
         rdata <= bdma_zero_byte;
      end
      else
      begin
         pointer_zero <= next_pointer_zero;
         pointer_one <= next_pointer_one;
         rdata <= next_rdata;
      end
   end

   // bank bit survives a watchdog wake reset, so it is outside the reset branch
   always_ff @(posedge clock_in)
   begin
      bank_select_bit <= next_bank_select_bit;
   end

   // ram holds no reset value; volatile contents
   always_ff @(posedge clock_in)
   begin
      if (gp_we && reset_n_in)
         gp_mem[gp_idx] <= gp_wdata;
   end

   assign rdata_out = rdata;
   assign bank_select_bit_out = bank_select_bit;
endmodule
`default_nettype wire

// File: hw/bdma_pkg.sv
// package: address map, field positions and access types for the banked data memory
package bdma_pkg;
   localparam int unsigned bdma_data_w = 8;
   localparam int unsigned bdma_addr_w = 8;

   // special-function map, shared by both banks
   localparam logic [7:0] bdma_addr_window_zero = 8'h00;
   localparam logic [7:0] bdma_addr_pointer_zero = 8'h01;
   localparam logic [7:0] bdma_addr_window_one = 8'h02;
   localparam logic [7:0] bdma_addr_pointer_one = 8'h03;
   localparam logic [7:0] bdma_addr_bank_select = 8'h04;
   localparam logic [7:0] bdma_addr_sfr_last = 8'h3f;

   // general-purpose area, bank 0 only; eeprom control shares its first address in bank 1
   localparam logic [7:0] bdma_addr_gp_first = 8'h40;
   localparam logic [7:0] bdma_addr_gp_last = 8'h7f;
   localparam logic [7:0] bdma_addr_eeprom_control = 8'h40;

   localparam int unsigned bdma_bank_bit = 0;
   localparam logic [7:0] bdma_bank_select_reset = 8'h00;
   localparam logic [7:0] bdma_zero_byte = 8'h00;
   localparam logic [7:0] bdma_one_byte = 8'h01;

   // kind of access issued by the core
   typedef enum logic [2:0]
   {
      bdma_op_none = 3'b000,
      bdma_op_read = 3'b001,
      bdma_op_write = 3'b010,
      bdma_op_bit_set = 3'b011,
      bdma_op_bit_clear = 3'b100
   } bdma_op_t;

   // one access request from the core
   typedef struct packed
   {
      bdma_op_t op;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [2:0] bit_sel;
   } bdma_req_t;

   // resolved location after window translation
   typedef struct packed
   {
      logic bank;
      logic [7:0] addr;
      logic null_target;
   } bdma_loc_t;
endpackage

// File: hw/bdma_resolve.sv
// address resolution: direct and window accesses to a bank and in-bank address
`timescale 1ns/1ps
`default_nettype none
module bdma_resolve
(
   // request address and pointer state
   input wire logic [7:0] addr_in,
   input wire logic [7:0] pointer_zero_in,
   input wire logic [7:0] pointer_one_in,
   input wire logic bank_sel_in,
   // resolved location
   output var bdma_pkg::bdma_loc_t loc_out
);
   import bdma_pkg::*;

   function automatic logic is_window(input logic [7:0] a);
      is_window = (a == bdma_addr_window_zero) || (a == bdma_addr_window_one);
   endfunction

   always_comb
   begin
      loc_out.bank = 1'b0;
      loc_out.addr = addr_in;
      loc_out.null_target = 1'b0;
      if (addr_in == bdma_addr_window_zero)
      begin
         loc_out.bank = 1'b0;
         loc_out.addr = pointer_zero_in;
         loc_out.null_target = is_window(pointer_zero_in);
      end
      else if (addr_in == bdma_addr_window_one)
      begin
         loc_out.bank = bank_sel_in;
         loc_out.addr = pointer_one_in;
         loc_out.null_target = is_window(pointer_one_in);
      end
   end
endmodule
`default_nettype wire
